// ===== rtl/dnms_pkg.sv
// dnms_pkg: constants, register map and carrier types of the down-converter front end
// assumes: a single 125 MHz clock domain and an apb register port with 32-bit data
package dnms_pkg;

    // =========================================================================
    // widths
    localparam int unsigned SAMPLE_W   = 12;
    localparam int unsigned OUT_W      = 15;
    localparam int unsigned FREQ_W     = 32;
    localparam int unsigned PHASE_W    = 16;
    localparam int unsigned RDIV_W     = 16;
    localparam int unsigned N_NCO      = 4;
    localparam int unsigned N_DDC      = 2;
    localparam int unsigned LUT_IDX_W  = 6;
    localparam int unsigned PROD_W     = 2 * SAMPLE_W;
    localparam int unsigned ACC_W      = PROD_W + 1;
    localparam int unsigned RND_SH     = ACC_W - OUT_W;
    localparam int unsigned RDIV_SHIFT = 6;    // divider counts in units of 64 clocks

    // =========================================================================
    // timing, in clock cycles
    localparam int unsigned GPIO_MIXER_CYC = 45;
    localparam int unsigned ADC_MIXER_CYC  = 37;

    // =========================================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_RDIV    = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_FREQ_A  = 8'h10;
    localparam logic [7:0] OFS_FREQ_B  = 8'h20;
    localparam logic [7:0] OFS_PHASE_A = 8'h30;
    localparam logic [7:0] OFS_PHASE_B = 8'h40;

    // =========================================================================
    // control register fields
    localparam int unsigned CTRL_W        = 14;
    localparam int unsigned CTRL_BYPASS   = 0;
    localparam int unsigned CTRL_SINGLE   = 1;
    localparam int unsigned CTRL_SRC      = 2;
    localparam int unsigned CTRL_BIND_A   = 3;
    localparam int unsigned CTRL_BIND_B   = 4;
    localparam int unsigned CTRL_SYNC_PIN = 5;
    localparam int unsigned CTRL_SEL_A    = 8;
    localparam int unsigned CTRL_SEL_B    = 10;
    localparam int unsigned CTRL_LINK_EN  = 12;
    localparam int unsigned CTRL_ARM      = 13;
    localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
    localparam logic [RDIV_W-1:0] RDIV_RST = 16'h0000;

    // status register fields
    localparam int unsigned STAT_IDX_A = 0;
    localparam int unsigned STAT_IDX_B = 2;
    localparam int unsigned STAT_ARM   = 4;

    // =========================================================================
    // register decode result
    typedef enum {
        REG_CTRL,
        REG_RDIV,
        REG_STATUS,
        REG_FREQ,
        REG_PHASE,
        REG_NONE
    } dnms_reg_e;

    // one output stream of a down converter
    typedef struct packed {
        logic                    valid;
        logic                    cplx;
        logic signed [OUT_W-1:0] i;
        logic signed [OUT_W-1:0] q;
    } dnms_out_s;

endpackage : dnms_pkg

// ===== rtl/dnms_nco_bank.sv
// dnms_nco_bank: free-running phase accumulators of one down converter and the phase mux
// assumes: restart is a one-cycle pulse in the pclk domain; index is already synchronous
module dnms_nco_bank
    import dnms_pkg::*;
#(
    parameter int unsigned N = N_NCO
) (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic [N-1:0][FREQ_W-1:0]         freq_words,
    input  wire logic [N-1:0][PHASE_W-1:0]        phase_offsets,
    input  wire logic                             restart,
    input  wire logic [$clog2(N)-1:0]             nco_index,
    output logic      [FREQ_W-1:0]                phase_out
);

    // =========================================================================
    // elaboration check
    if (N < 2 || (N & (N - 1)) != 0) begin : g_bad_n
        $error("dnms_nco_bank: N must be a power of two, at least 2");
    end

    // =========================================================================
    // accumulators
    logic [FREQ_W-1:0] acc_ff  [N];
    logic [FREQ_W-1:0] nxt_acc [N];
    logic [FREQ_W-1:0] phase_ff;
    logic [FREQ_W-1:0] nxt_phase;

    // every accumulator runs whether selected or not, so a hop resumes coherently
    for (genvar g = 0; g < N; g++) begin : g_acc
        always_comb begin
            nxt_acc[g] = restart ? '0 : acc_ff[g] + freq_words[g];
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                acc_ff[g] <= '0;
            end else begin
                acc_ff[g] <= nxt_acc[g];
            end
        end
    end

    // =========================================================================
    // selected phase plus left-justified offset
    always_comb begin
        nxt_phase = acc_ff[nco_index] + {phase_offsets[nco_index], {(FREQ_W - PHASE_W){1'b0}}};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign phase_out = phase_ff;

endmodule : dnms_nco_bank

// ===== rtl/dnms_ddc_front.sv
// dnms_ddc_front: converter sample routing, nco selection, complex mixer and decimating filter
// assumes: samples arrive every pclk; select pins are asynchronous; sync and sysref are synchronous
module dnms_ddc_front
    import dnms_pkg::*;
#(
    parameter int unsigned ADDR_W  = 8,
    parameter int unsigned SMP_DLY = ADC_MIXER_CYC,
    parameter int unsigned SEL_DLY = GPIO_MIXER_CYC
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic signed [SAMPLE_W-1:0] adc_a_sample,
    input  wire logic signed [SAMPLE_W-1:0] adc_b_sample,
    input  wire logic [1:0]                 ddc_a_nco_select_pins,
    input  wire logic [1:0]                 ddc_b_nco_select_pins,
    input  wire logic                       single_ended_sync_in,
    input  wire logic                       timestamp_diff_in,
    input  wire logic                       sysref,
    output dnms_out_s                       ddc_a_out,
    output dnms_out_s                       ddc_b_out
);

    // =========================================================================
    // elaboration check
    if (ADDR_W < 8 || SMP_DLY < 1 || SEL_DLY < 3) begin : g_bad_param
        $error("dnms_ddc_front: ADDR_W >= 8, SMP_DLY >= 1 and SEL_DLY >= 3 required");
    end

    localparam int unsigned SEL_TAIL = SEL_DLY - 2;
    localparam logic [RND_SH-1:0] HALF = {1'b1, {(RND_SH - 1){1'b0}}};
    localparam logic signed [OUT_W:0] OUT_MAX = {2'b00, {(OUT_W - 1){1'b1}}};
    localparam logic signed [OUT_W:0] OUT_MIN = {2'b11, {(OUT_W - 1){1'b0}}};

    // =========================================================================
    // functions
    function automatic dnms_reg_e reg_decode(input logic [ADDR_W-1:0] a);
        if (a[1:0] != 2'b00 || a[ADDR_W-1:7] != '0) begin
            return REG_NONE;
        end
        case (a[6:4])
            3'h0: begin
                if (a[3:0] == OFS_CTRL[3:0]) return REG_CTRL;
                if (a[3:0] == OFS_RDIV[3:0]) return REG_RDIV;
                if (a[3:0] == OFS_STATUS[3:0]) return REG_STATUS;
                return REG_NONE;
            end
            OFS_FREQ_A[6:4], OFS_FREQ_B[6:4]: return REG_FREQ;
            OFS_PHASE_A[6:4], OFS_PHASE_B[6:4]: return REG_PHASE;
            default: return REG_NONE;
        endcase
    endfunction : reg_decode

    // quarter-wave cosine, 17 points over 0..pi/2, amplitude 2047
    function automatic logic signed [SAMPLE_W-1:0] quarter(input logic [4:0] k);
        case (k)
            5'h00: return 12'h7ff;
            5'h01: return 12'h7f5;
            5'h02: return 12'h7d8;
            5'h03: return 12'h7a7;
            5'h04: return 12'h763;
            5'h05: return 12'h70d;
            5'h06: return 12'h6a6;
            5'h07: return 12'h62e;
            5'h08: return 12'h5a7;
            5'h09: return 12'h513;
            5'h0a: return 12'h471;
            5'h0b: return 12'h3c5;
            5'h0c: return 12'h30f;
            5'h0d: return 12'h252;
            5'h0e: return 12'h18f;
            5'h0f: return 12'h0c9;
            default: return 12'h000;
        endcase
    endfunction : quarter

    function automatic logic signed [SAMPLE_W-1:0] cos_lut(input logic [LUT_IDX_W-1:0] p);
        logic [4:0] k;
        logic [4:0] km;
        k  = {1'b0, p[3:0]};
        km = 5'h10 - k;
        case (p[5:4])
            2'h0: return quarter(k);
            2'h1: return -quarter(km);
            2'h2: return -quarter(k);
            default: return quarter(km);
        endcase
    endfunction : cos_lut

    // nearest code, ties to even, clipped to the output range
    function automatic logic signed [OUT_W-1:0] rne_sat(input logic signed [ACC_W-1:0] v);
        logic signed [OUT_W:0] t;
        logic [RND_SH-1:0]     f;
        logic                  up;
        t  = {v[ACC_W-1], v[ACC_W-1:RND_SH]};
        f  = v[RND_SH-1:0];
        up = (f > HALF) || (f == HALF && v[RND_SH]);
        t  = t + {{OUT_W{1'b0}}, up};
        if (t > OUT_MAX) t = OUT_MAX;
        if (t < OUT_MIN) t = OUT_MIN;
        return t[OUT_W-1:0];
    endfunction : rne_sat

    // =========================================================================
    // register file and apb slave
    logic [CTRL_W-1:0]                          ctrl_ff, nxt_ctrl;
    logic [RDIV_W-1:0]                          rdiv_ff, nxt_rdiv;
    logic [N_DDC-1:0][N_NCO-1:0][FREQ_W-1:0]    freq_ff, nxt_freq;
    logic [N_DDC-1:0][N_NCO-1:0][PHASE_W-1:0]   phase_ff, nxt_phase;
    logic [31:0]                                prdata_ff, nxt_prdata;
    logic                                       pslverr_ff, nxt_pslverr;
    logic [N_DDC-1:0][1:0]                      nco_idx;
    logic                                       sysref_rise;
    dnms_reg_e                                  kind;
    logic                                       ddc_sel;
    logic [1:0]                                 slot;
    logic                                       wr_en;

    assign kind    = reg_decode(paddr);
    assign ddc_sel = ~paddr[4];
    assign slot    = paddr[3:2];
    assign wr_en   = psel & penable & pwrite;
    assign pready  = psel & penable;

    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_rdiv  = rdiv_ff;
        nxt_freq  = freq_ff;
        nxt_phase = phase_ff;
        // hardware drops the arm bit once its sysref edge has been used
        if (ctrl_ff[CTRL_ARM] && sysref_rise) nxt_ctrl[CTRL_ARM] = 1'b0;
        // a software write in the same cycle wins, so a fresh arm is never lost
        if (wr_en) begin
            case (kind)
                REG_CTRL:  nxt_ctrl = pwdata[CTRL_W-1:0];
                REG_RDIV:  nxt_rdiv = pwdata[RDIV_W-1:0];
                REG_FREQ:  nxt_freq[ddc_sel][slot] = pwdata;
                REG_PHASE: nxt_phase[ddc_sel][slot] = pwdata[PHASE_W-1:0];
                default:   nxt_ctrl = nxt_ctrl;
            endcase
        end
        // read data and error are settled in the setup cycle
        nxt_prdata  = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (psel && !penable) begin
            nxt_pslverr = (kind == REG_NONE);
            nxt_prdata  = '0;
            case (kind)
                REG_CTRL:   nxt_prdata[CTRL_W-1:0] = ctrl_ff;
                REG_RDIV:   nxt_prdata[RDIV_W-1:0] = rdiv_ff;
                REG_FREQ:   nxt_prdata = freq_ff[ddc_sel][slot];
                REG_PHASE:  nxt_prdata[PHASE_W-1:0] = phase_ff[ddc_sel][slot];
                REG_STATUS: begin
                    nxt_prdata[STAT_IDX_A +: 2] = nco_idx[0];
                    nxt_prdata[STAT_IDX_B +: 2] = nco_idx[1];
                    nxt_prdata[STAT_ARM]        = ctrl_ff[CTRL_ARM];
                end
                default:    nxt_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff    <= CTRL_RST;
            rdiv_ff    <= RDIV_RST;
            freq_ff    <= '0;
            phase_ff   <= '0;
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            rdiv_ff    <= nxt_rdiv;
            freq_ff    <= nxt_freq;
            phase_ff   <= nxt_phase;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    // =========================================================================
    // phase synchronisation and rational wrap
    logic                       sync_prev_ff, nxt_sync_prev;
    logic                       sysref_prev_ff, nxt_sysref_prev;
    logic [RDIV_W+RDIV_SHIFT-1:0] rat_cnt_ff, nxt_rat_cnt;
    logic [RDIV_W+RDIV_SHIFT-1:0] rat_period;
    logic                       sync_level;
    logic                       nco_sync;
    logic                       rat_wrap;

    // either sync pin serves, whatever the link encoding
    assign sync_level  = ctrl_ff[CTRL_SYNC_PIN] ? timestamp_diff_in : single_ended_sync_in;
    assign sysref_rise = sysref & ~sysref_prev_ff;
    assign nco_sync    = (ctrl_ff[CTRL_LINK_EN] & sync_level & ~sync_prev_ff)
                       | (ctrl_ff[CTRL_ARM] & sysref_rise);
    assign rat_period  = {rdiv_ff, {RDIV_SHIFT{1'b0}}};
    // restarting every 64*divider clocks removes the drift of a rounded word
    assign rat_wrap    = (rdiv_ff != '0) && (rat_cnt_ff == rat_period - 1'b1);

    always_comb begin
        nxt_sync_prev   = sync_level;
        nxt_sysref_prev = sysref;
        nxt_rat_cnt     = (nco_sync || rat_wrap || rdiv_ff == '0) ? '0 : rat_cnt_ff + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_prev_ff   <= 1'b0;
            sysref_prev_ff <= 1'b0;
            rat_cnt_ff     <= '0;
        end else begin
            sync_prev_ff   <= nxt_sync_prev;
            sysref_prev_ff <= nxt_sysref_prev;
            rat_cnt_ff     <= nxt_rat_cnt;
        end
    end

    // =========================================================================
    // select pin synchroniser, hop delay, sample delay
    logic [N_DDC-1:0][1:0]              sel_meta_ff, nxt_sel_meta;
    logic [N_DDC-1:0][1:0]              sel_sync_ff, nxt_sel_sync;
    logic [1:0]                         sel_dly_ff  [N_DDC][SEL_TAIL];
    logic [1:0]                         nxt_sel_dly [N_DDC][SEL_TAIL];
    logic signed [SAMPLE_W-1:0]         smp_dly_ff  [N_DDC][SMP_DLY];
    logic signed [SAMPLE_W-1:0]         nxt_smp_dly [N_DDC][SMP_DLY];
    logic [N_DDC-1:0]                   bind_b;

    assign bind_b = {ctrl_ff[CTRL_BIND_B], ctrl_ff[CTRL_BIND_A]};

    always_comb begin
        nxt_sel_meta = {ddc_b_nco_select_pins, ddc_a_nco_select_pins};
        nxt_sel_sync = sel_meta_ff;
        for (int d = 0; d < N_DDC; d++) begin
            nxt_sel_dly[d][0] = sel_sync_ff[d];
            nxt_smp_dly[d][0] = bind_b[d] ? adc_b_sample : adc_a_sample;
            for (int i = 1; i < SEL_TAIL; i++) nxt_sel_dly[d][i] = sel_dly_ff[d][i-1];
            for (int i = 1; i < SMP_DLY; i++) nxt_smp_dly[d][i] = smp_dly_ff[d][i-1];
            nco_idx[d] = ctrl_ff[CTRL_SRC] ? sel_dly_ff[d][SEL_TAIL-1]
                                           : ctrl_ff[(d == 0 ? CTRL_SEL_A : CTRL_SEL_B) +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_meta_ff <= '0;
            sel_sync_ff <= '0;
            for (int d = 0; d < N_DDC; d++) begin
                for (int i = 0; i < SEL_TAIL; i++) sel_dly_ff[d][i] <= 2'h0;
                for (int i = 0; i < SMP_DLY; i++) smp_dly_ff[d][i] <= '0;
            end
        end else begin
            sel_meta_ff <= nxt_sel_meta;
            sel_sync_ff <= nxt_sel_sync;
            sel_dly_ff  <= nxt_sel_dly;
            smp_dly_ff  <= nxt_smp_dly;
        end
    end

    // =========================================================================
    // nco banks, mixer and decimate-by-two filter
    logic [FREQ_W-1:0]              nco_phase [N_DDC];
    logic signed [PROD_W-1:0]       prod_i_ff [N_DDC], nxt_prod_i [N_DDC];
    logic signed [PROD_W-1:0]       prod_q_ff [N_DDC], nxt_prod_q [N_DDC];
    logic signed [PROD_W-1:0]       keep_i_ff [N_DDC], nxt_keep_i [N_DDC];
    logic signed [PROD_W-1:0]       keep_q_ff [N_DDC], nxt_keep_q [N_DDC];
    logic                           odd_ff, nxt_odd;
    dnms_out_s                      out_ff [N_DDC], nxt_out [N_DDC];
    logic signed [SAMPLE_W-1:0]     mix_s;
    logic [LUT_IDX_W-1:0]           lut_p;

    for (genvar d = 0; d < N_DDC; d++) begin : g_bank
        dnms_nco_bank #(
            .N             (N_NCO)
        ) u_bank (
            .pclk          (pclk),
            .presetn       (presetn),
            .freq_words    (freq_ff[d]),
            .phase_offsets (phase_ff[d]),
            .restart       (nco_sync | rat_wrap),
            .nco_index     (nco_idx[d]),
            .phase_out     (nco_phase[d])
        );
    end

    always_comb begin
        nxt_odd = ~odd_ff;
        mix_s   = '0;
        lut_p   = '0;
        for (int d = 0; d < N_DDC; d++) begin
            mix_s = smp_dly_ff[d][SMP_DLY-1];
            lut_p = nco_phase[d][FREQ_W-1 -: LUT_IDX_W];
            // real sample times cos and sin of the nco phase
            nxt_prod_i[d] = mix_s * cos_lut(lut_p);
            nxt_prod_q[d] = mix_s * cos_lut(lut_p - 6'h10);
            nxt_keep_i[d] = odd_ff ? keep_i_ff[d] : prod_i_ff[d];
            nxt_keep_q[d] = odd_ff ? keep_q_ff[d] : prod_q_ff[d];
            nxt_out[d]    = '0;
            if (ctrl_ff[CTRL_BYPASS]) begin
                nxt_out[d].valid = 1'b1;
                nxt_out[d].i     = {{(OUT_W - SAMPLE_W){mix_s[SAMPLE_W-1]}}, mix_s};
            end else if (!(d == 1 && ctrl_ff[CTRL_SINGLE]) && odd_ff) begin
                nxt_out[d].valid = 1'b1;
                nxt_out[d].cplx  = 1'b1;
                // sum at full width, one rounding at the filter output
                nxt_out[d].i = rne_sat(ACC_W'(keep_i_ff[d]) + ACC_W'(prod_i_ff[d]));
                nxt_out[d].q = rne_sat(ACC_W'(keep_q_ff[d]) + ACC_W'(prod_q_ff[d]));
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odd_ff <= 1'b0;
            for (int d = 0; d < N_DDC; d++) begin
                prod_i_ff[d] <= '0;
                prod_q_ff[d] <= '0;
                keep_i_ff[d] <= '0;
                keep_q_ff[d] <= '0;
                out_ff[d]    <= '0;
            end
        end else begin
            odd_ff    <= nxt_odd;
            prod_i_ff <= nxt_prod_i;
            prod_q_ff <= nxt_prod_q;
            keep_i_ff <= nxt_keep_i;
            keep_q_ff <= nxt_keep_q;
            out_ff    <= nxt_out;
        end
    end

    assign ddc_a_out = out_ff[0];
    assign ddc_b_out = out_ff[1];

endmodule : dnms_ddc_front

// ===== dv/dnms_ddc_front_assertions.sv
// port checker of the down-converter front end
// assumes: bound to dnms_ddc_front with an 8-bit paddr and one pclk domain
module dnms_chk
    import dnms_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [1:0]  ddc_a_nco_select_pins,
    input wire dnms_out_s   ddc_a_out,
    input wire dnms_out_s   ddc_b_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // =========================================
    // shadow control and settle counters
    // counters saturate so a quiet run never falls back into the unsettled window
    logic [13:0] ctrl_ff, nxt_ctrl;
    logic [6:0]  cnt_ff, nxt_cnt, pcnt_ff, nxt_pcnt;
    logic [1:0]  pins_ff;
    wire wr_ctrl = psel && penable && pwrite && paddr == OFS_CTRL;
    wire rd_stat = psel && penable && !pwrite && paddr == OFS_STATUS;
    wire settled = cnt_ff > 7'h3f;
    wire byp     = ctrl_ff[CTRL_BYPASS] && settled;
    wire ddc     = !ctrl_ff[CTRL_BYPASS] && settled;
    always_comb begin
        nxt_ctrl = wr_ctrl ? pwdata[13:0] : ctrl_ff;
        nxt_cnt  = wr_ctrl ? 7'h00 : cnt_ff + 7'(cnt_ff != 7'h7f);
        nxt_pcnt = (ddc_a_nco_select_pins != pins_ff) ? 7'h00 : pcnt_ff + 7'(pcnt_ff != 7'h7f);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ctrl_ff, cnt_ff, pcnt_ff, pins_ff} <= '0;
        end else begin
            {ctrl_ff, cnt_ff, pcnt_ff, pins_ff} <= {nxt_ctrl, nxt_cnt, nxt_pcnt, ddc_a_nco_select_pins};
        end
    end
    // =========================================
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_bypass_real: assert property (byp && ddc_a_out.valid |-> !ddc_a_out.cplx && ddc_a_out.q == '0)
        else $error("bypass output not real");
    a_bypass_every: assert property (byp |-> ddc_a_out.valid [*2])
        else $error("bypass output gap");
    a_ddc_complex: assert property (ddc && ddc_a_out.valid |-> ddc_a_out.cplx)
        else $error("mixer output not complex");
    a_ddc_decim: assert property (ddc && ddc_a_out.valid |=> !ddc_a_out.valid ##1 ddc_a_out.valid)
        else $error("decimated rate wrong");
    a_single_b_idle: assert property (ddc && ctrl_ff[CTRL_SINGLE] |-> !ddc_b_out.valid)
        else $error("second converter active");
    a_sel_field: assert property (rd_stat && !ctrl_ff[CTRL_SRC] |->
        prdata[3:0] == {ctrl_ff[CTRL_SEL_B +: 2], ctrl_ff[CTRL_SEL_A +: 2]}) else $error("field select lost");
    a_sel_pins: assert property (rd_stat && ctrl_ff[CTRL_SRC] && settled && pcnt_ff > 7'h44 |->
        prdata[1:0] == ddc_a_nco_select_pins) else $error("pin select late");
    a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
endmodule : dnms_chk

// ===== dv/dnms_far_end.sv
// link receiver model: drives the sync level and sysref pulses
// assumes: tasks are called just after a pclk edge; sync starts asserted low
module dnms_far_end (
    input  wire logic pclk,
    output logic      single_ended_sync_in,
    output logic      sysref
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        single_ended_sync_in = 1'b0;
        sysref = 1'b0;
    end
    // =========================================
    // link events
    task automatic release_sync;
        @(posedge pclk) single_ended_sync_in <= 1'b1;
    endtask : release_sync
    // one pulse only, sysref is held low around it
    task automatic sysref_pulse;
        @(posedge pclk) sysref <= 1'b1;
        @(posedge pclk) sysref <= 1'b0;
    endtask : sysref_pulse
endmodule : dnms_far_end

// ===== dv/tb_ddc_nco_mixer_select.sv
// self-checking bench of the down-converter front end
// assumes: zero-wait apb slave, cos of phase 0 is 2047, converter a frequency words left at 0
module tb_ddc_nco_mixer_select
    import dnms_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, single_ended_sync_in, sysref, timestamp_diff_in = 1'b0;
    logic signed [11:0] adc_a_sample = '0, adc_b_sample = '0;
    logic [1:0] ddc_a_nco_select_pins = '0, ddc_b_nco_select_pins = '0;
    dnms_out_s ddc_a_out, ddc_b_out;
    int errors = 0, n_checks = 0, seed = 34, k;
    int ts[3] = '{256, 768, -256};
    int te[3] = '{1024, 3070, -1024};
    logic [63:0] rq[$];
    logic [29:0] sq[$];
    initial forever #4 pclk = ~pclk;
    dnms_ddc_front u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .adc_a_sample, .adc_b_sample, .ddc_a_nco_select_pins, .ddc_b_nco_select_pins,
        .single_ended_sync_in, .timestamp_diff_in, .sysref, .ddc_a_out, .ddc_b_out);
    dnms_far_end u_far (.pclk, .single_ended_sync_in, .sysref);
    // =========================================
    // tasks
    task automatic test_done;
        if (errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [31:0] a, input logic [31:0] b);
        n_checks++;
        if (a !== b) begin
            errors++;
            $display("Error at %0t got %h expected %h", $time, a, b);
        end
    endtask : cmp
    // a read with a nonzero mask notes its expected word before the setup cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        int n;
        @(posedge pclk);
        if (!w && m != '0) rq.push_back({m, d});
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 9; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 9) begin errors++; test_done(); end
        {psel, penable} <= 2'b00;
    endtask : apb
    // waits past the sample pipeline, then expects i = v and q = 0
    task automatic smp(input int v);
        int n;
        repeat (70) @(posedge pclk);
        sq.push_back({15'(v), 15'h0000});
        for (n = 0; n < 9 && sq.size() > 0; n++) @(posedge pclk);
        if (sq.size() > 0) begin errors++; test_done(); end
    endtask : smp
    always @(posedge pclk) begin : watch
        logic [63:0] e;
        if (psel === 1'b1 && penable === 1'b1 && rq.size() > 0) begin
            e = rq.pop_front();
            cmp(prdata & e[63:32], e[31:0] & e[63:32]);
        end
        if (ddc_a_out.valid === 1'b1 && sq.size() > 0) cmp(32'({ddc_a_out.i, ddc_a_out.q}), 32'(sq.pop_front()));
    end
    // =========================================
    // scenarios
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0, 32'hffffffff);
        apb(1'b0, 8'h0d, 32'h0, 32'hffffffff);
        apb(1'b1, OFS_CTRL, 32'h1, 32'h0);
        adc_a_sample <= 12'sd256;
        smp(256);
        apb(1'b1, OFS_CTRL, 32'h0, 32'h0);
        for (k = 0; k < 3; k++) begin
            adc_a_sample <= 12'(ts[k]);
            smp(te[k]);
        end
        adc_a_sample <= 12'($random(seed));
        adc_b_sample <= 12'sd768;
        apb(1'b1, OFS_CTRL, 32'h8, 32'h0);
        smp(3070);
        adc_a_sample <= 12'sd256;
        apb(1'b1, OFS_PHASE_A + 8'h08, 32'h8000, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h200, 32'h0);
        smp(-1024);
        apb(1'b0, OFS_STATUS, 32'h2, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h4, 32'h0);
        repeat (80) @(posedge pclk);
        ddc_a_nco_select_pins <= 2'h2;
        ddc_b_nco_select_pins <= 2'($random(seed));
        repeat (20) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0, 32'h3);
        repeat (60) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h2, 32'h3);
        smp(-1024);
        apb(1'b1, OFS_CTRL, 32'h2002, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h10, 32'h10);
        u_far.sysref_pulse();
        apb(1'b0, OFS_STATUS, 32'h0, 32'h10);
        apb(1'b1, OFS_CTRL, 32'h1002, 32'h0);
        u_far.release_sync();
        repeat (80) @(posedge pclk);
        apb(1'b1, OFS_RDIV, 32'h780, 32'h0);
        apb(1'b0, OFS_RDIV, 32'h780, 32'hffff);
        apb(1'b1, OFS_FREQ_B + 8'h04, 32'h89abcdef, 32'h0);
        apb(1'b0, OFS_FREQ_B + 8'h04, 32'h89abcdef, 32'hffffffff);
        test_done();
    end
endmodule : tb_ddc_nco_mixer_select

bind dnms_ddc_front dnms_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pslverr, .ddc_a_nco_select_pins, .ddc_a_out, .ddc_b_out);
